// ---- rtl/mp_regs_defines.svh ----
`ifndef MP_REGS_DEFINES_SVH
`define MP_REGS_DEFINES_SVH

// Register select codes on the register address field
`define REG_ACC        4'h0
`define REG_FLAGS      4'h1
`define REG_DISC_FIRST 4'h2
`define REG_DISC_SEC   4'h3
`define REG_PTR_UPPER  4'h4
`define REG_PTR_LOWER  4'h5
`define REG_EXT_FIRST  4'h6

// Condition flag bit positions
`define FLAG_LINK      0
`define FLAG_SIGN      1
`define FLAG_POS       2
`define FLAG_ZERO      3
`define FLAG_OVF       4
`define FLAG_PAR       5
`define FLAG_EXT_FIRST 6
`define FLAG_EXT_SEC   7

// Reset values
`define PTR_RESET      12'hfff
`define DATA_RESET     8'h00
`define FLAGS_RESET    8'h00

// Timing, in nanoseconds, and derived clock counts (least times round up)
`define CLK_PERIOD_NS  100
`define CYCLE_NS       260
`define JUMP_NS        520
`define CYCLE_CLKS     ((`CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define JUMP_CLKS      ((`JUMP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- rtl/mp_regs_pkg.sv ----
package mp_regs_pkg;

   // Micro-instruction operation classes
   typedef enum logic [3:0] {
      OP_NOP, OP_LIT_R, OP_OR_R, OP_XOR_R, OP_AND_R, OP_ADD, OP_SUB, OP_R_TO_S,
      OP_LIT_S, OP_TEST_XOR, OP_TEST_AND, OP_JUMP, OP_JCOND, OP_INC_R, OP_DEC_R
   } op_t;

   // Sequencer phases
   typedef enum logic {
      SEQ_FETCH, SEQ_EXEC
   } seq_t;

   // Micro-instruction word layout
   typedef struct packed {
      op_t        op;
      logic [3:0] rSel;
      logic [7:0] low;
   } instr_t;

   // Read return bus with its parity line
   typedef struct packed {
      logic       parity;
      logic [7:0] data;
   } rbus_t;

   // Condition flag register layout
   typedef struct packed {
      logic extSec;
      logic extFirst;
      logic par;
      logic ovf;
      logic zero;
      logic pos;
      logic sign;
      logic link;
   } cond_flags_t;

   // Operation stores its result into the named register
   function automatic logic op_writes_reg(op_t op);
      case (op)
         OP_LIT_R, OP_OR_R, OP_XOR_R, OP_AND_R, OP_ADD, OP_SUB, OP_INC_R, OP_DEC_R: op_writes_reg = 1'b1;
         default: op_writes_reg = 1'b0;
      endcase
   endfunction : op_writes_reg

   // Operation takes the named register as an operand
   function automatic logic op_reads_reg(op_t op);
      case (op)
         OP_OR_R, OP_XOR_R, OP_AND_R, OP_ADD, OP_SUB, OP_R_TO_S, OP_TEST_XOR, OP_TEST_AND, OP_INC_R,
         OP_DEC_R: op_reads_reg = 1'b1;
         default: op_reads_reg = 1'b0;
      endcase
   endfunction : op_reads_reg

endpackage : mp_regs_pkg

// ---- rtl/scratch_pad.sv ----
`timescale 1ns/1ps
`default_nettype none
module scratch_pad #(
   parameter int DEPTH = 16,
   parameter int WIDTH = 8
) (
   // Clock
   input  wire logic                     core_clk,
   // Write port
   input  wire logic                     writeEn,
   input  wire logic [$clog2(DEPTH)-1:0] writeAddr,
   input  wire logic [WIDTH-1:0]         writeData,
   // Read port
   input  wire logic [$clog2(DEPTH)-1:0] readAddr,
   output logic      [WIDTH-1:0]         readData
);

   // Refuse shapes the address field cannot reach
   if (DEPTH < 2 || DEPTH != (1 << $clog2(DEPTH)) || WIDTH < 1) begin : g_check
      $error("scratch_pad: DEPTH must be a power of two and WIDTH positive");
   end

   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge core_clk) begin
      if (writeEn) begin
         mem[writeAddr] <= writeData;
      end
   end

   // Asynchronous read for operand staging
   assign readData = mem[readAddr];

endmodule : scratch_pad
`default_nettype wire

// ---- rtl/flag_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mp_regs_defines.svh"
module flag_unit import mp_regs_pkg::*; #(
   parameter bit ODD_PARITY = 1'b1
) (
   // Clock and reset
   input  wire logic  core_clk,
   input  wire logic  reset,
   // Instruction outcome
   input  wire logic  commit,
   input  wire logic  arith,
   input  wire logic  logicOp,
   input  wire logic  carry,
   input  wire logic  signIn,
   input  wire logic  overflow,
   input  wire logic  [7:0] result,
   // Parity check of read return bus
   input  wire logic  parCheck,
   input  wire rbus_t readBus,
   // Software write of the flag register
   input  wire logic  writeFlags,
   input  wire logic  [7:0] writeData,
   // Synchronised external conditions
   input  wire logic  [1:0] extCond,
   // Flag register
   output cond_flags_t flags
);

   logic        parErr;
   cond_flags_t base;

   // Bad parity under the selected convention
   assign parErr = ODD_PARITY ? ~(^readBus) : (^readBus);

   // Written value first, operation outcome on top
   always_comb begin
      base = flags;
      if (writeFlags) begin
         base = cond_flags_t'(writeData);
      end
   end

   // Condition bits, one process so the register has a single driver
   always_ff @(posedge core_clk) begin
      if (reset) begin
         flags <= cond_flags_t'(`FLAGS_RESET);
      end else begin
         flags.extFirst <= extCond[0];
         flags.extSec   <= extCond[1];
         if (commit) begin
            flags.link <= base.link;
            flags.sign <= base.sign;
            flags.ovf  <= base.ovf;
            flags.pos  <= base.pos;
            flags.zero <= base.zero;
            if (arith) begin
               flags.link <= carry;
               flags.sign <= signIn;
               flags.ovf  <= overflow;
            end
            if (arith || logicOp) begin
               flags.pos  <= ~result[7] && (result != 8'h00);
               flags.zero <= (result == 8'h00);
            end
            flags.par <= (parCheck && parErr) || base.par;
         end
      end
   end

   property p_par_set;
      @(posedge core_clk) disable iff (reset)
      (commit && parCheck && parErr) |=> flags.par;
   endproperty
   a_par_set: assert property (p_par_set) else $error("parity error flag not set");

   property p_zero_flag;
      @(posedge core_clk) disable iff (reset)
      (commit && (arith || logicOp)) |=> (flags.zero == ($past(result) == 8'h00));
   endproperty
   a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

   property p_link_flag;
      @(posedge core_clk) disable iff (reset)
      (commit && arith) |=> (flags.link == $past(carry));
   endproperty
   a_link_flag: assert property (p_link_flag) else $error("link flag wrong");

   // Parity error seen
   c_par_err: cover property (@(posedge core_clk) disable iff (reset) commit && parCheck && parErr);

endmodule : flag_unit
`default_nettype wire

// ---- rtl/microprocessor_register_set.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mp_regs_defines.svh"
module microprocessor_register_set import mp_regs_pkg::*; #(
   parameter int CYCLE_CLKS = `CYCLE_CLKS,
   parameter int JUMP_CLKS  = `JUMP_CLKS,
   parameter bit ODD_PARITY = 1'b1
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // Program memory
   output logic      [11:0] fetchAddr,
   output logic             fetchInitiate,
   input  wire logic [15:0] instrBus,
   // Register bus
   output logic      [3:0]  regAddr,
   input  wire rbus_t       readBus,
   output logic      [7:0]  resultBus,
   output logic             sinkLine,
   output logic             writeStrobe,
   // Discrete outputs and external conditions
   output logic      [7:0]  discreteFirst,
   output logic      [7:0]  discreteSecond,
   input  wire logic [1:0]  extCondition
);

   // Refuse timings the sequencer cannot serve
   if (CYCLE_CLKS < 3 || JUMP_CLKS < CYCLE_CLKS || JUMP_CLKS > 255) begin : g_check
      $error("microprocessor_register_set: need 3 <= CYCLE_CLKS <= JUMP_CLKS <= 255");
   end

   localparam logic [7:0] CYC_LAST  = 8'(CYCLE_CLKS - 1);
   localparam logic [7:0] JUMP_LAST = 8'(JUMP_CLKS - 1);
   localparam int         EXEC_WAIT = CYCLE_CLKS - 1;
   localparam int         JUMP_WAIT = JUMP_CLKS - 1;

   instr_t      instrSync1_r, instrSync2_r, instr_r;
   rbus_t       readSync1_r, readSync2_r;
   logic [1:0]  extSync1_r, extSync2_r;
   seq_t        state_r;
   logic [11:0] pointer_r, newPtr;
   logic [7:0]  phaseCnt_r, acc_r, discFirst_r, discSecond_r, resultBus_r, execLast;
   logic [7:0]  sOperand, rOperand, addB, resultComb, scratchData;
   logic [3:0]  regAddr_r, scratchAddr;
   logic [8:0]  sum9;
   cond_flags_t flags;
   logic        fetchInit_r, sink_r, strobe_r, scratchWe;
   logic        subtract, writesR, arith, logicOp, overflow, jumpLoad, lastFetch, lastExec;

   // Two-stage synchronisers for the instruction, read bus and external condition inputs
   always_ff @(posedge core_clk) begin
      if (reset) begin
         instrSync1_r <= instr_t'(16'h0000);
         instrSync2_r <= instr_t'(16'h0000);
         readSync1_r  <= rbus_t'(9'h000);
         readSync2_r  <= rbus_t'(9'h000);
         extSync1_r   <= 2'h0;
         extSync2_r   <= 2'h0;
      end else begin
         instrSync1_r <= instr_t'(instrBus);
         instrSync2_r <= instrSync1_r;
         readSync1_r  <= readBus;
         readSync2_r  <= readSync1_r;
         extSync1_r   <= extCondition;
         extSync2_r   <= extSync1_r;
      end
   end

   // Operand selection by register code
   always_comb begin
      case (instr_r.rSel)
         `REG_ACC:        rOperand = acc_r;
         `REG_FLAGS:      rOperand = flags;
         `REG_DISC_FIRST: rOperand = discFirst_r;
         `REG_DISC_SEC:   rOperand = discSecond_r;
         `REG_PTR_UPPER:  rOperand = 8'h00;
         `REG_PTR_LOWER:  rOperand = 8'h00;
         default:         rOperand = readSync2_r.data;
      endcase
   end

   // Adder and result selection
   always_comb begin
      subtract = (instr_r.op == OP_SUB) || (instr_r.op == OP_DEC_R);
      addB     = ((instr_r.op == OP_INC_R) || (instr_r.op == OP_DEC_R)) ? 8'h01 : sOperand;
      sum9     = subtract ? ({1'b0, rOperand} + {1'b0, ~addB} + 9'h001) : ({1'b0, rOperand} + {1'b0, addB});
      overflow = subtract ? ((rOperand[7] != addB[7]) && (sum9[7] != rOperand[7]))
                          : ((rOperand[7] == addB[7]) && (sum9[7] != rOperand[7]));
      case (instr_r.op)
         OP_OR_R:                    resultComb = rOperand | instr_r.low;
         OP_XOR_R, OP_TEST_XOR:      resultComb = rOperand ^ instr_r.low;
         OP_AND_R, OP_TEST_AND:      resultComb = rOperand & instr_r.low;
         OP_ADD, OP_SUB, OP_INC_R,
         OP_DEC_R:                   resultComb = sum9[7:0];
         OP_R_TO_S:                  resultComb = rOperand;
         OP_LIT_R, OP_LIT_S, OP_JUMP: resultComb = instr_r.low;
         default:                    resultComb = 8'h00;
      endcase
      arith   = (instr_r.op == OP_ADD) || (instr_r.op == OP_SUB) || (instr_r.op == OP_INC_R) || (instr_r.op == OP_DEC_R);
      logicOp = (instr_r.op == OP_OR_R) || (instr_r.op == OP_XOR_R) || (instr_r.op == OP_AND_R) ||
                (instr_r.op == OP_TEST_XOR) || (instr_r.op == OP_TEST_AND);
      writesR = op_writes_reg(instr_r.op);
   end

   // Pointer load decode and execution length
   always_comb begin
      jumpLoad = 1'b0;
      newPtr   = pointer_r;
      if (instr_r.op == OP_JUMP) begin
         jumpLoad = 1'b1;
         newPtr   = {resultComb[3:0], acc_r};
      end else if (instr_r.op == OP_JCOND) begin
         jumpLoad = (flags[instr_r.rSel[2:0]] == instr_r.rSel[3]);
         newPtr   = {pointer_r[11:8], instr_r.low};
      end else if (writesR && (instr_r.rSel == `REG_PTR_UPPER)) begin
         jumpLoad = 1'b1;
         newPtr   = {resultComb[3:0], pointer_r[7:0]};
      end else if (writesR && (instr_r.rSel == `REG_PTR_LOWER)) begin
         jumpLoad = 1'b1;
         newPtr   = {pointer_r[11:8], resultComb};
      end
      execLast  = jumpLoad ? JUMP_LAST : CYC_LAST;
      lastFetch = (state_r == SEQ_FETCH) && (phaseCnt_r == CYC_LAST);
      lastExec  = (state_r == SEQ_EXEC) && (phaseCnt_r >= execLast);
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_r    <= SEQ_EXEC;
         phaseCnt_r <= 8'h00;
      end else begin
         case (state_r)
            SEQ_FETCH: begin
               phaseCnt_r <= lastFetch ? 8'h00 : phaseCnt_r + 8'h01;
               state_r    <= lastFetch ? SEQ_EXEC : SEQ_FETCH;
            end
            SEQ_EXEC: begin
               phaseCnt_r <= lastExec ? 8'h00 : phaseCnt_r + 8'h01;
               state_r    <= lastExec ? SEQ_FETCH : SEQ_EXEC;
            end
            default: begin
               phaseCnt_r <= 8'h00;
               state_r    <= SEQ_FETCH;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         pointer_r <= `PTR_RESET;
      end else if (lastExec) begin
         pointer_r <= jumpLoad ? newPtr : pointer_r + 12'h001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         instr_r   <= instr_t'(16'h0000);
         regAddr_r <= `REG_ACC;
         sink_r    <= 1'b0;
      end else if (lastFetch) begin
         instr_r   <= instrSync2_r;
         regAddr_r <= instrSync2_r.rSel;
         sink_r    <= op_writes_reg(instrSync2_r.op);
      end
   end

   // Initiate spans the fetch; strobe follows execution
   always_ff @(posedge core_clk) begin
      if (reset) begin
         fetchInit_r <= 1'b0;
         strobe_r    <= 1'b0;
         resultBus_r <= `DATA_RESET;
      end else begin
         fetchInit_r <= lastExec ? 1'b1 : (lastFetch ? 1'b0 : fetchInit_r);
         strobe_r    <= lastExec;
         if (lastExec) begin
            resultBus_r <= resultComb;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         acc_r        <= `DATA_RESET;
         discFirst_r  <= `DATA_RESET;
         discSecond_r <= `DATA_RESET;
      end else if (lastExec && writesR) begin
         if (instr_r.rSel == `REG_ACC) begin
            acc_r <= resultComb;
         end
         if (instr_r.rSel == `REG_DISC_FIRST) begin
            discFirst_r <= resultComb;
         end
         if (instr_r.rSel == `REG_DISC_SEC) begin
            discSecond_r <= resultComb;
         end
      end
   end

   // Scratch write port
   assign scratchWe   = lastExec && ((instr_r.op == OP_R_TO_S) || (instr_r.op == OP_LIT_S));
   assign scratchAddr = (instr_r.op == OP_LIT_S) ? instr_r.rSel : instr_r.low[7:4];
   assign scratchData = resultComb;

   scratch_pad #(
      .DEPTH (16),
      .WIDTH (8)
   ) u_scratch (
      .core_clk  (core_clk),
      .writeEn   (scratchWe),
      .writeAddr (scratchAddr),
      .writeData (scratchData),
      .readAddr  (instr_r.low[7:4]),
      .readData  (sOperand)
   );

   flag_unit #(
      .ODD_PARITY (ODD_PARITY)
   ) u_flags (
      .core_clk   (core_clk),
      .reset      (reset),
      .commit     (lastExec),
      .arith      (arith),
      .logicOp    (logicOp),
      .carry      (sum9[8]),
      .signIn     (rOperand[7]),
      .overflow   (overflow),
      .result     (resultComb),
      .parCheck   (op_reads_reg(instr_r.op) && (instr_r.rSel >= `REG_EXT_FIRST)),
      .readBus    (readSync2_r),
      .writeFlags (writesR && (instr_r.rSel == `REG_FLAGS)),
      .writeData  (resultComb),
      .extCond    (extSync2_r),
      .flags      (flags)
   );

   // Outputs straight from flops
   assign fetchAddr      = pointer_r;
   assign fetchInitiate  = fetchInit_r;
   assign regAddr        = regAddr_r;
   assign resultBus      = resultBus_r;
   assign sinkLine       = sink_r;
   assign writeStrobe    = strobe_r;
   assign discreteFirst  = discFirst_r;
   assign discreteSecond = discSecond_r;

   property p_exec_len;
      @(posedge core_clk) disable iff (reset)
      (state_r == SEQ_EXEC && phaseCnt_r == 8'h00 && !jumpLoad) |-> ##EXEC_WAIT lastExec;
   endproperty
   a_exec_len: assert property (p_exec_len) else $error("ordinary execution length wrong");
   property p_jump_len;
      @(posedge core_clk) disable iff (reset)
      (state_r == SEQ_EXEC && phaseCnt_r == 8'h00 && jumpLoad) |-> ##JUMP_WAIT lastExec;
   endproperty
   a_jump_len: assert property (p_jump_len) else $error("jump execution length wrong");
   property p_increment;
      @(posedge core_clk) disable iff (reset)
      (lastExec && !jumpLoad) |=> (fetchAddr == $past(fetchAddr) + 12'h001) && fetchInitiate;
   endproperty
   a_increment: assert property (p_increment) else $error("pointer not incremented before fetch");
   property p_holder;
      @(posedge core_clk) disable iff (reset)
      (state_r == SEQ_EXEC && $past(state_r) == SEQ_EXEC) |-> $stable(instr_r) && $stable(regAddr);
   endproperty
   a_holder: assert property (p_holder) else $error("instruction changed during execution");
   property p_jump_acc;
      @(posedge core_clk) disable iff (reset)
      (lastExec && instr_r.op == OP_JUMP) |=> (fetchAddr[7:0] == $past(acc_r));
   endproperty
   a_jump_acc: assert property (p_jump_acc) else $error("jump low byte not from accumulator");
   property p_upper_write;
      @(posedge core_clk) disable iff (reset)
      (lastExec && writesR && instr_r.rSel == `REG_PTR_UPPER) |=> (fetchAddr[11:8] == $past(resultComb[3:0]));
   endproperty
   a_upper_write: assert property (p_upper_write) else $error("upper pointer part not loaded");
   property p_disc_first;
      @(posedge core_clk) disable iff (reset)
      (lastExec && writesR && instr_r.rSel == `REG_DISC_FIRST) |=> (discreteFirst == $past(resultComb));
   endproperty
   a_disc_first: assert property (p_disc_first) else $error("first discrete output not updated");

   property p_strobe_sink;
      @(posedge core_clk) disable iff (reset)
      (lastExec && writesR) |=> writeStrobe && sinkLine && (resultBus == $past(resultComb));
   endproperty
   a_strobe_sink: assert property (p_strobe_sink) else $error("strobe without sink or result");

   c_jump: cover property (@(posedge core_clk) disable iff (reset) lastExec && instr_r.op == OP_JUMP);
   c_ext_write: cover property (@(posedge core_clk) disable iff (reset) writeStrobe && sinkLine && regAddr >= 4'h6);
   c_cond_taken: cover property (@(posedge core_clk) disable iff (reset) lastExec && instr_r.op == OP_JCOND && jumpLoad);

endmodule : microprocessor_register_set
`default_nettype wire

// ---- tb/ext_reg_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ext_reg_model import mp_regs_pkg::*; (
   // Processor side
   input  wire logic       core_clk,
   input  wire logic [3:0] regAddr,
   input  wire logic [7:0] resultBus,
   input  wire logic       sinkLine,
   input  wire logic       writeStrobe,
   // Fault control
   input  wire logic       badPar,
   output rbus_t           readBus
);
   logic [7:0] regs [16];
   logic [7:0] idle = 8'h5a;
   always @(posedge core_clk) if (writeStrobe && sinkLine && regAddr >= 4'h6) regs[regAddr] <= resultBus;
   // Unselected bus toggles
   always @(posedge core_clk) idle <= ~idle;
   assign readBus = (regAddr >= 4'h6) ? {~^regs[regAddr] ^ badPar, regs[regAddr]} : {idle[0], idle};
endmodule : ext_reg_model
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb import mp_regs_pkg::*;;
   logic        core_clk = 0, reset = 1, fetchInitiate, sinkLine, writeStrobe, badPar = 0;
   logic [11:0] fetchAddr;
   logic [15:0] instrBus = 16'h0000;
   logic [3:0]  regAddr;
   rbus_t       readBus;
   logic [7:0]  resultBus, discreteFirst, discreteSecond, v, w, res, flg, u, mdl [16];
   logic [1:0]  extCondition = 2'h0;
   int          error_cnt = 0, checked = 0, seed = 25632, p = 0, n, s;
   // Clock
   initial forever #50 core_clk = ~core_clk;
   microprocessor_register_set #(.CYCLE_CLKS(3), .JUMP_CLKS(6), .ODD_PARITY(1'b1)) i_microprocessor_register_set (
      .core_clk(core_clk), .reset(reset), .fetchAddr(fetchAddr), .fetchInitiate(fetchInitiate),
      .instrBus(instrBus), .regAddr(regAddr), .readBus(readBus), .resultBus(resultBus), .sinkLine(sinkLine),
      .writeStrobe(writeStrobe), .discreteFirst(discreteFirst), .discreteSecond(discreteSecond),
      .extCondition(extCondition));
   ext_reg_model i_ext_reg_model (.core_clk(core_clk), .regAddr(regAddr), .resultBus(resultBus),
      .sinkLine(sinkLine), .writeStrobe(writeStrobe), .badPar(badPar), .readBus(readBus));
   // Compare and count
   task check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Verdict
   task tally_and_finish;
      $display("compares %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : tally_and_finish
   // One instruction, entered at first falling edge of its fetch
   task run(input op_t op, input logic [3:0] rs, input logic [7:0] lit, input logic [7:0] exp,
            input logic [7:0] mask, input int nxt, input int cyc);
      instrBus = {op, rs, lit};
      check(fetchAddr, p[11:0]);
      n = 0;
      while (fetchInitiate && n < 20) begin @(negedge core_clk); n++; end
      while (!fetchInitiate && n < 20) begin @(negedge core_clk); n++; end
      check(resultBus & mask, exp & mask);
      check(fetchAddr, nxt[11:0]);
      check(n[15:0], cyc[15:0]);
      p = nxt;
   endtask : run
   // Reference arithmetic: result and flag bits 5..0 (parity error already set)
   task alu(input op_t op, input logic [7:0] a, input logic [7:0] b);
      s = (op == OP_SUB) ? a + 256 - b : a + b;
      res = s[7:0];
      flg = {2'b00, 1'b1, (a[7] == (b[7] ^ (op == OP_SUB))) && (res[7] != a[7]),
             res == 8'h00, !res[7] && res != 8'h00, a[7], s[8]};
   endtask : alu
   // Main sequence
   initial begin
      repeat (2) @(negedge core_clk);
      reset = 0;
      n = 0;
      while (!fetchInitiate && n < 20) begin @(negedge core_clk); n++; end
      check(fetchAddr, 12'h000);
      // Write then combine every register but the flags; pointer parts, which read zero, are only combined
      for (int i = 0; i < 16; i++) begin
         v = $random(seed);
         w = $random(seed);
         if (i == 4 || i == 5) begin
            run(OP_TEST_XOR, i[3:0], v, v, 8'hff, p + 1, 6);
         end else if (i != 1) begin
            run(OP_LIT_R, i[3:0], v, v, 8'hff, p + 1, 6);
            run(OP_OR_R, i[3:0], w, v | w, 8'hff, p + 1, 6);
            mdl[i] = v | w;
         end
      end
      check(discreteFirst, mdl[2]);
      check(discreteSecond, mdl[3]);
      // Bad parity and external conditions
      extCondition = 2'($random(seed));
      badPar = 1;
      run(OP_TEST_XOR, 4'h6, 8'h00, mdl[6], 8'hff, p + 1, 6);
      badPar = 0;
      run(OP_OR_R, 4'h1, 8'h00, {extCondition[1], extCondition[0], 6'h20}, 8'he0, p + 1, 6);
      // Arithmetic through the scratch pad, flags read back
      run(OP_LIT_S, 4'h3, w, w, 8'hff, p + 1, 6);
      alu(OP_ADD, mdl[0], w);
      run(OP_ADD, 4'h0, 8'h30, res, 8'hff, p + 1, 6);
      mdl[0] = res;
      run(OP_OR_R, 4'h1, 8'h00, flg, 8'h3f, p + 1, 6);
      run(OP_R_TO_S, 4'h2, 8'h50, mdl[2], 8'hff, p + 1, 6);
      alu(OP_SUB, mdl[0], mdl[2]);
      run(OP_SUB, 4'h0, 8'h50, res, 8'hff, p + 1, 6);
      mdl[0] = res;
      run(OP_OR_R, 4'h1, 8'h00, flg, 8'h3f, p + 1, 6);
      // Conditional jump on the link bit, both ways
      u = $random(seed);
      run(OP_JCOND, {~flg[0], 3'h0}, u, 8'h00, 8'h00, p + 1, 6);
      run(OP_JCOND, {flg[0], 3'h0}, u, 8'h00, 8'h00, {p[11:8], u}, 9);
      // Index and logic operations on registers
      run(OP_INC_R, 4'h3, 8'h00, mdl[3] + 8'h01, 8'hff, p + 1, 6);
      run(OP_AND_R, 4'h7, u, mdl[7] & u, 8'hff, p + 1, 6);
      run(OP_XOR_R, 4'h7, w, (mdl[7] & u) ^ w, 8'hff, p + 1, 6);
      run(OP_DEC_R, 4'h3, 8'h00, mdl[3], 8'hff, p + 1, 6);
      run(OP_NOP, 4'h0, 8'h00, 8'h00, 8'h00, p + 1, 6);
      check(discreteSecond, mdl[3]);
      // Jumps through accumulator and pointer parts
      run(OP_JUMP, 4'h0, 8'h03, 8'h00, 8'h00, {4'h3, mdl[0]}, 9);
      v = $random(seed);
      run(OP_LIT_R, 4'h5, v, v, 8'hff, {p[11:8], v}, 9);
      run(OP_LIT_R, 4'h4, 8'h0a, 8'h0a, 8'hff, {4'ha, p[7:0]}, 9);
      tally_and_finish();
   end
   // Watchdog
   initial begin
      #(100 * 2000);
      error_cnt++;
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
